// ===== src/pin_driver.sv
`timescale 1ns/1ps
// per-pin output stage: direction, open drain, slew and analog gating
module pin_driver (
  input wire logic latch_bit, // output latch value
  input wire logic dir_bit, // 1 = input
  input wire logic od_bit, // 1 = open drain
  input wire logic slew_bit, // 1 = slew limited
  input wire logic ansel_bit, // 1 = analog mode
  input wire logic st_level, // synchronised schmitt level
  input wire logic ttl_level, // synchronised ttl level
  input wire logic thr_bit, // 1 = schmitt, 0 = ttl
  output logic pin_out, // pin output value
  output logic pin_oe, // pin output enable
  output logic pin_slew, // slew limit to pad
  output logic analog_en, // analog path enabled
  output logic digital_in // value seen by digital reads
);
  always_comb begin
    // analog select does not touch digital drive
    if (dir_bit) begin
      pin_oe = 1'b0;
      pin_out = 1'b0;
    end else if (od_bit) begin
      pin_oe = ~latch_bit;
      pin_out = 1'b0;
    end else begin
      pin_oe = 1'b1;
      pin_out = latch_bit;
    end
    pin_slew = slew_bit;
    analog_en = ansel_bit;
    digital_in = ansel_bit ? 1'b0 : (thr_bit ? st_level : ttl_level);
  end
endmodule

// ===== src/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser per pin for both threshold receivers
module pin_sync (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] raw_in, // asynchronous pin level
  output logic [7:0] sync_out // synchronised level
);
  logic [7:0] stage_one;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      stage_one <= raw_in;
      sync_out <= stage_one;
    end
  end
endmodule

// ===== src/port_c.sv
`timescale 1ns/1ps
module port_c #(
  parameter int PINS = port_c_pkg::PIN_COUNT // 6 or 8
) (
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] addr, // register index
  input wire logic [7:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [7:0] rdata, // read data, cycle after strobe
  input wire logic [7:0] pin_st_in, // schmitt receiver levels
  input wire logic [7:0] pin_ttl_in, // ttl receiver levels
  output logic [7:0] pin_out, // pin output values
  output logic [7:0] pin_oe, // pin output enables
  output logic [7:0] pin_slew, // slew limit per pad
  output logic [7:0] analog_en // analog path enable per pin
);
  localparam logic [7:0] PIN_MASK = 8'((1 << PINS) - 1);
  localparam logic [1:0] SYNC_DEPTH = 2'h2;

  logic [7:0] direction;
  logic [7:0] output_latch;
  logic [7:0] analog_select;
  logic [7:0] open_drain;
  logic [7:0] slew_limit;
  logic [7:0] input_threshold;
  logic [7:0] st_sync;
  logic [7:0] ttl_sync;
  logic [7:0] digital_in;
  logic [7:0] next_rdata;
  logic [1:0] sync_warm;

  pin_sync u_st_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw_in(pin_st_in),
    .sync_out(st_sync)
  );

  pin_sync u_ttl_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw_in(pin_ttl_in),
    .sync_out(ttl_sync)
  );

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      if (i < PINS) begin : g_used
        pin_driver u_drv (
          .latch_bit(output_latch[i]),
          .dir_bit(direction[i]),
          .od_bit(open_drain[i]),
          .slew_bit(slew_limit[i]),
          .ansel_bit(analog_select[i]),
          .st_level(st_sync[i]),
          .ttl_level(ttl_sync[i]),
          .thr_bit(input_threshold[i]),
          .pin_out(pin_out[i]),
          .pin_oe(pin_oe[i]),
          .pin_slew(pin_slew[i]),
          .analog_en(analog_en[i]),
          .digital_in(digital_in[i])
        );
      end else begin : g_absent
        assign pin_out[i] = 1'b0;
        assign pin_oe[i] = 1'b0;
        assign pin_slew[i] = 1'b0;
        assign analog_en[i] = 1'b0;
        assign digital_in[i] = 1'b0;
      end
    end
  endgenerate

  // direction register, all inputs after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      direction <= port_c_pkg::RESET_DIRECTION;
    end else if (wr_en && addr == port_c_pkg::ADDR_DIRECTION) begin
      direction <= wdata | ~PIN_MASK;
    end
  end

  // output latch: data writes load wdata straight into the latch, same as latch writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_latch <= port_c_pkg::RESET_OUTPUT_LATCH;
    end else if (wr_en && addr == port_c_pkg::ADDR_PIN_DATA) begin
      output_latch <= wdata & PIN_MASK;
    end else if (wr_en && addr == port_c_pkg::ADDR_OUTPUT_LATCH) begin
      output_latch <= wdata & PIN_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_select <= port_c_pkg::RESET_ANALOG_SELECT;
    end else if (wr_en && addr == port_c_pkg::ADDR_ANALOG_SELECT) begin
      analog_select <= wdata & PIN_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_drain <= port_c_pkg::RESET_OPEN_DRAIN;
    end else if (wr_en && addr == port_c_pkg::ADDR_OPEN_DRAIN) begin
      open_drain <= wdata & PIN_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slew_limit <= port_c_pkg::RESET_SLEW_LIMIT & PIN_MASK;
    end else if (wr_en && addr == port_c_pkg::ADDR_SLEW_LIMIT) begin
      slew_limit <= wdata & PIN_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_threshold <= port_c_pkg::RESET_INPUT_THRESHOLD & PIN_MASK;
    end else if (wr_en && addr == port_c_pkg::ADDR_INPUT_THRESHOLD) begin
      input_threshold <= wdata & PIN_MASK;
    end
  end

  always_comb begin
    unique case (addr)
      port_c_pkg::ADDR_PIN_DATA: next_rdata = digital_in & PIN_MASK;
      port_c_pkg::ADDR_DIRECTION: next_rdata = direction & PIN_MASK;
      port_c_pkg::ADDR_OUTPUT_LATCH: next_rdata = output_latch;
      port_c_pkg::ADDR_ANALOG_SELECT: next_rdata = analog_select & PIN_MASK;
      port_c_pkg::ADDR_OPEN_DRAIN: next_rdata = open_drain;
      port_c_pkg::ADDR_SLEW_LIMIT: next_rdata = slew_limit;
      port_c_pkg::ADDR_INPUT_THRESHOLD: next_rdata = input_threshold;
      default: next_rdata = port_c_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= port_c_pkg::READ_ZERO;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= port_c_pkg::READ_ZERO;
    end
  end

  // counts the synchroniser stages after reset so pin checks skip stale flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_warm <= 2'h0;
    end else if (sync_warm != SYNC_DEPTH) begin
      sync_warm <= sync_warm + 2'h1;
    end
  end

  a_input_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (direction[0] |-> !pin_oe[0]))
    else $error("input pin driven");

  a_output_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!direction[0] && !open_drain[0]) |-> (pin_oe[0] && pin_out[0] == output_latch[0]))
    else $error("output pin not driving latch");

  a_open_drain: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pin_oe[1] && open_drain[1]) |-> !pin_out[1])
    else $error("open drain drove high");

  a_pp_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!direction[1] && !open_drain[1] && output_latch[1]) |-> (pin_oe[1] && pin_out[1]))
    else $error("push-pull not driving high");

  a_analog_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_en && addr == port_c_pkg::ADDR_PIN_DATA && analog_select[2]) |=> !rdata[2])
    else $error("analog pin read nonzero");

  a_analog_output: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (analog_select[3] && !direction[3] && !open_drain[3]) |-> pin_oe[3])
    else $error("analog select blocked output");

  a_latch_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr == port_c_pkg::ADDR_PIN_DATA) |=> output_latch == ($past(wdata) & PIN_MASK))
    else $error("port write did not reach latch");

  a_slew_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin_slew[4] == slew_limit[4])
    else $error("slew output mismatch");

  a_reset_input: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (direction == port_c_pkg::RESET_DIRECTION))
    else $error("pins not inputs after reset");

  a_analog_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
    analog_en[5] == analog_select[5])
    else $error("analog path mismatch");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rd_en |=> (rdata == port_c_pkg::READ_ZERO))
    else $error("read data outside read cycle");

  a_dir_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_en && addr == port_c_pkg::ADDR_DIRECTION) |=>
    (rdata == ($past(direction) & PIN_MASK)))
    else $error("direction readback wrong");

  a_latch_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_en && addr == port_c_pkg::ADDR_OUTPUT_LATCH) |=> (rdata == $past(output_latch)))
    else $error("latch readback wrong");

  a_dir_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr == port_c_pkg::ADDR_DIRECTION) |=>
    (direction == ($past(wdata) | ~PIN_MASK)))
    else $error("direction write lost");

  a_analog_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr == port_c_pkg::ADDR_ANALOG_SELECT) |=>
    (analog_select == ($past(wdata) & PIN_MASK)))
    else $error("analog select write lost");

  a_od_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr == port_c_pkg::ADDR_OPEN_DRAIN) |=>
    (open_drain == ($past(wdata) & PIN_MASK)))
    else $error("open drain write lost");

  a_slew_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr == port_c_pkg::ADDR_SLEW_LIMIT) |=>
    (slew_limit == ($past(wdata) & PIN_MASK)))
    else $error("slew limit write lost");

  a_level_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr == port_c_pkg::ADDR_INPUT_THRESHOLD) |=>
    (input_threshold == ($past(wdata) & PIN_MASK)))
    else $error("threshold write lost");

  a_latch_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr == port_c_pkg::ADDR_PIN_DATA) |=>
    ($stable(direction) && $stable(analog_select) && $stable(open_drain)))
    else $error("port write touched pin setup");

  a_unmapped_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && addr > port_c_pkg::ADDR_INPUT_THRESHOLD) |=>
    ($stable(direction) && $stable(output_latch) && $stable(analog_select) &&
    $stable(open_drain) && $stable(slew_limit) && $stable(input_threshold)))
    else $error("unmapped write changed a register");

  a_st_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_warm == SYNC_DEPTH) |-> (st_sync == $past(pin_st_in, 2)))
    else $error("schmitt level not two stages late");

  a_ttl_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_warm == SYNC_DEPTH) |-> (ttl_sync == $past(pin_ttl_in, 2)))
    else $error("ttl level not two stages late");

  a_absent_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (((pin_oe | pin_out | pin_slew | analog_en) & ~PIN_MASK) == port_c_pkg::READ_ZERO))
    else $error("absent pin active");

  generate
    for (i = 0; i < PINS; i++) begin : g_check
      a_pin_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
        direction[i] |-> !pin_oe[i])
        else $error("input pin driven");

      a_od_sink: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!direction[i] && open_drain[i]) |-> (pin_oe[i] == !output_latch[i] && !pin_out[i]))
        else $error("open drain pin sourced current");

      a_push_pull: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!direction[i] && !open_drain[i]) |-> (pin_oe[i] && pin_out[i] == output_latch[i]))
        else $error("push-pull pin not driving latch");

      a_slew_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pin_slew[i] == slew_limit[i])
        else $error("slew pin mismatch");

      a_analog_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        analog_en[i] == analog_select[i])
        else $error("analog pin mismatch");

      a_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == port_c_pkg::ADDR_PIN_DATA && analog_select[i]) |=> !rdata[i])
        else $error("analog pin read high");

      a_read_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == port_c_pkg::ADDR_PIN_DATA && !analog_select[i]) |=>
        (rdata[i] == ($past(input_threshold[i]) ? $past(st_sync[i]) : $past(ttl_sync[i]))))
        else $error("pin read used wrong receiver");
    end
  endgenerate
endmodule

// ===== src/port_c_pkg.sv
package port_c_pkg;
  // port width: 6 pins on the small package, 8 on the large one
  localparam int PIN_COUNT = 8;
  localparam int ADDR_WIDTH = 4;

  // register indices on the plain register port
  localparam logic [3:0] ADDR_PIN_DATA = 4'h0;
  localparam logic [3:0] ADDR_DIRECTION = 4'h1;
  localparam logic [3:0] ADDR_OUTPUT_LATCH = 4'h2;
  localparam logic [3:0] ADDR_ANALOG_SELECT = 4'h3;
  localparam logic [3:0] ADDR_OPEN_DRAIN = 4'h4;
  localparam logic [3:0] ADDR_SLEW_LIMIT = 4'h5;
  localparam logic [3:0] ADDR_INPUT_THRESHOLD = 4'h6;

  // reset values
  localparam logic [7:0] RESET_DIRECTION = 8'hFF;
  localparam logic [7:0] RESET_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RESET_ANALOG_SELECT = 8'hFF;
  localparam logic [7:0] RESET_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RESET_SLEW_LIMIT = 8'hFF;
  localparam logic [7:0] RESET_INPUT_THRESHOLD = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// ===== verification/bidirectional_port_c_bench.sv
`timescale 1ns/1ps
module bidirectional_port_c_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata, pin_st_in, pin_ttl_in, pin_out, pin_oe, pin_slew, analog_en;
  logic [7:0] ext_val = 8'hA5;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] ext_mid = 8'h0F;
  int miscompares = 0;
  int tests_run = 0;

  always #10 ref_clk = ~ref_clk;

  port_c dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .pin_st_in(pin_st_in), .pin_ttl_in(pin_ttl_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_slew(pin_slew), .analog_en(analog_en));

  port_c_pins pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en),
    .ext_mid(ext_mid), .pin_st_in(pin_st_in), .pin_ttl_in(pin_ttl_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #40000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(pin_oe, 8'h00);
    chk(analog_en, 8'hFF);
    chk(pin_slew, 8'hFF);
    rd(port_c_pkg::ADDR_DIRECTION, 8'hFF);
    rd(port_c_pkg::ADDR_OUTPUT_LATCH, 8'h00);
    rd(port_c_pkg::ADDR_OPEN_DRAIN, 8'h00);
    rd(port_c_pkg::ADDR_INPUT_THRESHOLD, 8'hFF);
    rd(4'h7, 8'h00);
    rd(port_c_pkg::ADDR_PIN_DATA, 8'h00);
    wr(port_c_pkg::ADDR_ANALOG_SELECT, 8'h00);
    settle();
    rd(port_c_pkg::ADDR_PIN_DATA, 8'hA0);
    wr(port_c_pkg::ADDR_INPUT_THRESHOLD, 8'h00);
    settle();
    rd(port_c_pkg::ADDR_PIN_DATA, 8'hAF);
    wr(port_c_pkg::ADDR_INPUT_THRESHOLD, 8'hFF);
    wr(port_c_pkg::ADDR_PIN_DATA, 8'h3C);
    chk(pin_oe, 8'h00);
    rd(port_c_pkg::ADDR_OUTPUT_LATCH, 8'h3C);
    rd(port_c_pkg::ADDR_PIN_DATA, 8'hA0);
    ext_en <= 8'h00;
    wr(port_c_pkg::ADDR_DIRECTION, 8'h00);
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'h3C);
    settle();
    rd(port_c_pkg::ADDR_PIN_DATA, 8'h3C);
    wr(port_c_pkg::ADDR_OPEN_DRAIN, 8'hFF);
    chk(pin_oe, 8'hC3);
    chk(pin_out, 8'h00);
    settle();
    rd(port_c_pkg::ADDR_PIN_DATA, 8'h3C);
    wr(port_c_pkg::ADDR_OPEN_DRAIN, 8'h00);
    chk(pin_oe, 8'hFF);
    wr(port_c_pkg::ADDR_SLEW_LIMIT, 8'h0F);
    chk(pin_slew, 8'h0F);
    wr(port_c_pkg::ADDR_ANALOG_SELECT, 8'hFF);
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'h3C);
    chk(analog_en, 8'hFF);
    settle();
    rd(port_c_pkg::ADDR_PIN_DATA, 8'h00);
    wr(port_c_pkg::ADDR_PIN_DATA, 8'h00 | 8'h01);
    rd(port_c_pkg::ADDR_OUTPUT_LATCH, 8'h01);
    chk(pin_out, 8'h01);
    wr(port_c_pkg::ADDR_DIRECTION, 8'hFF);
    chk(pin_oe, 8'h00);
    wr(4'h7, 8'h00);
    rd(port_c_pkg::ADDR_DIRECTION, 8'hFF);
    @(negedge ref_clk);
    chk(rdata, 8'h00);
    wr(port_c_pkg::ADDR_DIRECTION, 8'h00);
    chk(pin_oe, 8'hFF);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(pin_oe, 8'h00);
    chk(analog_en, 8'hFF);
    rd(port_c_pkg::ADDR_OUTPUT_LATCH, 8'h00);
    rd(port_c_pkg::ADDR_SLEW_LIMIT, 8'hFF);
    rd(port_c_pkg::ADDR_PIN_DATA, 8'h00);
    complete_run();
  end
endmodule

// ===== verification/port_c_pins.sv
`timescale 1ns/1ps
// external circuitry: pull-ups, optional drivers, marginal levels
module port_c_pins (
  input wire logic [7:0] pin_out, // device output value
  input wire logic [7:0] pin_oe, // device output enable
  input wire logic [7:0] ext_val, // external drive value
  input wire logic [7:0] ext_en, // external driver active
  input wire logic [7:0] ext_mid, // level between the two thresholds
  output logic [7:0] pin_st_in, // schmitt receiver view
  output logic [7:0] pin_ttl_in // ttl receiver view
);
  logic [7:0] level;
  // a released pin with no external driver floats up through the pull-up
  assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
  // a mid-level voltage from an external driver passes ttl as high, schmitt as low
  assign pin_st_in = level & ~(ext_mid & ext_en & ~pin_oe);
  assign pin_ttl_in = level | (ext_mid & ext_en & ~pin_oe);
endmodule
